// [core/occ_params.svh]
// Constants for the output channel configuration register bank
// Overview of operation
// - Source select: off, DAC, bypass, both
// - Codes 4/5 split DAC and bypass pins
// - Routing select: differential, single-ended, mono, pseudo
// - Common-mode bit: reference fraction or half-supply
// - Low power only valid for DAC, non-stereo
// - Positive drive type: line, headphone, 4 ohm, debug
// - Positive level codes 4..7 give -8..-26 dB
// - Bandwidth bit: audio or wide mode
// - Reserved bits read zero, ignore writes
// - Negative drive and level mirror positive encodings
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH

// Register addresses
`define OCC_ADDR_SOURCE_ROUTING 8'h64
`define OCC_ADDR_DRIVE_LEVEL_POS 8'h65
`define OCC_ADDR_DRIVE_LEVEL_NEG 8'h66

// Reset values
`define OCC_RESET_SOURCE_ROUTING 8'h20
`define OCC_RESET_DRIVE_LEVEL_POS 8'h20
`define OCC_RESET_DRIVE_LEVEL_NEG 8'h20

// Writable bit masks; cleared bits are reserved
`define OCC_MASK_SOURCE_ROUTING 8'hFF
`define OCC_MASK_DRIVE_LEVEL_POS 8'hF9
`define OCC_MASK_DRIVE_LEVEL_NEG 8'hFB

// Field positions
`define OCC_SRC_MSB 7
`define OCC_SRC_LSB 5
`define OCC_ROUTE_MSB 4
`define OCC_ROUTE_LSB 2
`define OCC_VCOM_BIT 1
`define OCC_LP_BIT 0
`define OCC_DRIVE_MSB 7
`define OCC_DRIVE_LSB 6
`define OCC_LEVEL_MSB 5
`define OCC_LEVEL_LSB 3
`define OCC_BW_BIT 0

// Source codes
`define OCC_SRC_OFF 3'h0
`define OCC_SRC_DAC 3'h1
`define OCC_SRC_BYPASS 3'h2
`define OCC_SRC_BOTH 3'h3
`define OCC_SRC_SPLIT_DAC_POS 3'h4
`define OCC_SRC_SPLIT_DAC_NEG 3'h5

// Routing codes
`define OCC_ROUTE_DIFF 3'h0
`define OCC_ROUTE_STEREO_SE 3'h1
`define OCC_ROUTE_MONO_POS 3'h2
`define OCC_ROUTE_MONO_NEG 3'h3
`define OCC_ROUTE_PSEUDO_NEG_VCOM 3'h4
`define OCC_ROUTE_PSEUDO_NEG_VCOM_SENSE 3'h5
`define OCC_ROUTE_PSEUDO_POS_VCOM 3'h6

// Level codes and attenuation in dB
`define OCC_LEVEL_MIN_LEGAL 3'h4
`define OCC_ATTEN_L4 5'h08
`define OCC_ATTEN_L5 5'h0E
`define OCC_ATTEN_L6 5'h14
`define OCC_ATTEN_L7 5'h1A

`endif

// [core/occ_pkg.sv]
// Types shared by the output channel configuration register bank
package occ_pkg;

	typedef enum logic [1:0] {
		OCC_DRIVE_LINE = 2'h0,
		OCC_DRIVE_HEADPHONE = 2'h1,
		OCC_DRIVE_FOUR_OHM = 2'h2,
		OCC_DRIVE_DEBUG = 2'h3
	} occ_drive_t;

	// One analog output stage
	typedef struct packed {
		occ_drive_t driveType;
		logic [4:0] attenuationDb;
		logic levelLegal;
	} occ_stage_t;

	// Signal paths onto the two output pins
	typedef struct packed {
		logic driverEnable;
		logic posFromDac;
		logic posFromBypass;
		logic posIsVcom;
		logic negFromDac;
		logic negFromBypass;
		logic negIsVcom;
		logic senseOnSecond;
	} occ_route_t;

	// Global analog settings
	typedef struct packed {
		logic commonModeHalfSupply;
		logic lowPowerActive;
		logic wideBandwidth;
	} occ_analog_t;

	// Reserved or forbidden codes currently stored
	typedef struct packed {
		logic sourceReserved;
		logic routingReserved;
		logic posLevelIllegal;
		logic negLevelIllegal;
	} occ_fault_t;

endpackage

// [core/occ_field_reg.sv]
// One eight-bit configuration register with reserved-bit masking
`timescale 1ns/1ps
`default_nettype none

module occ_field_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hFF
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic writeEnable,
	input wire logic [7:0] writeData,
	output logic [7:0] value
);

	// Reserved positions keep their reset value whatever is written
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			value <= RESET_VALUE;
		end else if (writeEnable) begin
			value <= (writeData & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
		end
	end

endmodule

`default_nettype wire

// [core/occ_stage_decode.sv]
// Decodes drive type and level code for one output stage
`timescale 1ns/1ps
`include "occ_params.svh"
`default_nettype none

module occ_stage_decode (
	input wire logic [1:0] driveCode,
	input wire logic [2:0] levelCode,
	output occ_pkg::occ_stage_t stage
);

	always_comb begin
		stage.driveType = occ_pkg::occ_drive_t'(driveCode);
		stage.levelLegal = (levelCode >= `OCC_LEVEL_MIN_LEGAL);
		case (levelCode)
			3'h4: stage.attenuationDb = `OCC_ATTEN_L4;
			3'h5: stage.attenuationDb = `OCC_ATTEN_L5;
			3'h6: stage.attenuationDb = `OCC_ATTEN_L6;
			3'h7: stage.attenuationDb = `OCC_ATTEN_L7;
			// Forbidden codes fall back to the least loud setting
			default: stage.attenuationDb = `OCC_ATTEN_L7;
		endcase
	end

endmodule

`default_nettype wire

// [core/occ_output_config.sv]
// Output channel configuration register bank with analog control decode
`timescale 1ns/1ps
`include "occ_params.svh"
`default_nettype none

module occ_output_config (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	output logic regAck,
	output logic regHit,
	output occ_pkg::occ_route_t route,
	output occ_pkg::occ_analog_t analog,
	output occ_pkg::occ_stage_t posStage,
	output occ_pkg::occ_stage_t negStage,
	output occ_pkg::occ_fault_t fault
);

	logic selSourceRouting;
	logic selDriveLevelPos;
	logic selDriveLevelNeg;
	logic mapped;
	logic [7:0] sourceRouting;
	logic [7:0] driveLevelPos;
	logic [7:0] driveLevelNeg;
	logic [7:0] next_regReadData;
	logic [2:0] sourceCode;
	logic [2:0] routingCode;
	occ_pkg::occ_route_t next_route;
	occ_pkg::occ_analog_t next_analog;
	occ_pkg::occ_stage_t next_posStage;
	occ_pkg::occ_stage_t next_negStage;
	occ_pkg::occ_fault_t next_fault;
	logic dacActive;
	logic bypassActive;

	// Write enables and field views of the stored bytes
	logic writeSourceRouting;
	logic writeDriveLevelPos;
	logic writeDriveLevelNeg;
	logic requestValid;
	logic requestMapped;
	logic sourceUsesRouting;
	logic lowPowerAllowed;
	logic commonModeBit;
	logic lowPowerBit;
	logic bandwidthBit;
	logic [1:0] posDriveCode;
	logic [2:0] posLevelCode;
	logic [1:0] negDriveCode;
	logic [2:0] negLevelCode;

	// Address decode
	always_comb begin
		selSourceRouting = 1'b0;
		selDriveLevelPos = 1'b0;
		selDriveLevelNeg = 1'b0;
		// Full-byte compare, so no alias of the bank ever answers
		if (regAddr == `OCC_ADDR_SOURCE_ROUTING) begin
			selSourceRouting = 1'b1;
		end else if (regAddr == `OCC_ADDR_DRIVE_LEVEL_POS) begin
			selDriveLevelPos = 1'b1;
		end else if (regAddr == `OCC_ADDR_DRIVE_LEVEL_NEG) begin
			selDriveLevelNeg = 1'b1;
		end
	end

	assign mapped = selSourceRouting | selDriveLevelPos | selDriveLevelNeg;

	// Unmapped addresses write nothing but are still acknowledged
	assign writeSourceRouting = regWrite & selSourceRouting;
	assign writeDriveLevelPos = regWrite & selDriveLevelPos;
	assign writeDriveLevelNeg = regWrite & selDriveLevelNeg;
	assign requestValid = regRead | regWrite;
	assign requestMapped = requestValid & mapped;

	// Storage
	occ_field_reg #(
		.RESET_VALUE(`OCC_RESET_SOURCE_ROUTING),
		.WRITE_MASK(`OCC_MASK_SOURCE_ROUTING)
	) u_sourceRouting (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.writeEnable(writeSourceRouting),
		.writeData(regWriteData),
		.value(sourceRouting)
	);

	occ_field_reg #(
		.RESET_VALUE(`OCC_RESET_DRIVE_LEVEL_POS),
		.WRITE_MASK(`OCC_MASK_DRIVE_LEVEL_POS)
	) u_driveLevelPos (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.writeEnable(writeDriveLevelPos),
		.writeData(regWriteData),
		.value(driveLevelPos)
	);

	occ_field_reg #(
		.RESET_VALUE(`OCC_RESET_DRIVE_LEVEL_NEG),
		.WRITE_MASK(`OCC_MASK_DRIVE_LEVEL_NEG)
	) u_driveLevelNeg (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.writeEnable(writeDriveLevelNeg),
		.writeData(regWriteData),
		.value(driveLevelNeg)
	);

	// Read mux; reserved bits are already zero in storage
	always_comb begin
		next_regReadData = 8'h00;
		if (selSourceRouting) begin
			next_regReadData = sourceRouting;
		end else if (selDriveLevelPos) begin
			next_regReadData = driveLevelPos;
		end else if (selDriveLevelNeg) begin
			next_regReadData = driveLevelNeg;
		end
	end

	// Read data holds between reads; a read beside a write returns the old byte
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			regReadData <= 8'h00;
		end else if (regRead) begin
			regReadData <= next_regReadData;
		end
	end

	// Every strobe is answered, so a host never stalls on an unmapped address
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			regAck <= 1'b0;
		end else begin
			regAck <= requestValid;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			regHit <= 1'b0;
		end else begin
			regHit <= requestMapped;
		end
	end

	// Field extraction
	assign sourceCode = sourceRouting[`OCC_SRC_MSB:`OCC_SRC_LSB];
	assign routingCode = sourceRouting[`OCC_ROUTE_MSB:`OCC_ROUTE_LSB];
	assign dacActive = (sourceCode == `OCC_SRC_DAC) || (sourceCode == `OCC_SRC_BOTH);
	assign bypassActive = (sourceCode == `OCC_SRC_BYPASS) || (sourceCode == `OCC_SRC_BOTH);
	assign sourceUsesRouting = (sourceCode < `OCC_SRC_SPLIT_DAC_POS);

	// Field views
	assign commonModeBit = sourceRouting[`OCC_VCOM_BIT];
	assign lowPowerBit = sourceRouting[`OCC_LP_BIT];
	assign bandwidthBit = driveLevelPos[`OCC_BW_BIT];
	assign posDriveCode = driveLevelPos[`OCC_DRIVE_MSB:`OCC_DRIVE_LSB];
	assign posLevelCode = driveLevelPos[`OCC_LEVEL_MSB:`OCC_LEVEL_LSB];
	assign negDriveCode = driveLevelNeg[`OCC_DRIVE_MSB:`OCC_DRIVE_LSB];
	assign negLevelCode = driveLevelNeg[`OCC_LEVEL_MSB:`OCC_LEVEL_LSB];

	// Low power is ignored off the DAC-only path and in stereo single-ended use
	assign lowPowerAllowed = (sourceCode == `OCC_SRC_DAC)
		&& (routingCode != `OCC_ROUTE_STEREO_SE);

	// Pin routing
	always_comb begin
		next_route = '0;
		case (sourceCode)
			`OCC_SRC_DAC, `OCC_SRC_BYPASS, `OCC_SRC_BOTH: begin
				next_route.driverEnable = 1'b1;
				case (routingCode)
					`OCC_ROUTE_DIFF, `OCC_ROUTE_STEREO_SE: begin
						next_route.posFromDac = dacActive;
						next_route.posFromBypass = bypassActive;
						next_route.negFromDac = dacActive;
						next_route.negFromBypass = bypassActive;
					end
					`OCC_ROUTE_MONO_POS: begin
						next_route.posFromDac = dacActive;
						next_route.posFromBypass = bypassActive;
					end
					`OCC_ROUTE_MONO_NEG: begin
						next_route.negFromDac = dacActive;
						next_route.negFromBypass = bypassActive;
					end
					`OCC_ROUTE_PSEUDO_NEG_VCOM, `OCC_ROUTE_PSEUDO_NEG_VCOM_SENSE: begin
						next_route.posFromDac = dacActive;
						next_route.posFromBypass = bypassActive;
						next_route.negIsVcom = 1'b1;
						next_route.senseOnSecond = (routingCode == `OCC_ROUTE_PSEUDO_NEG_VCOM_SENSE);
					end
					`OCC_ROUTE_PSEUDO_POS_VCOM: begin
						next_route.negFromDac = dacActive;
						next_route.negFromBypass = bypassActive;
						next_route.posIsVcom = 1'b1;
					end
					default: begin
						// Reserved routing keeps the driver muted rather than guess a topology
						next_route.driverEnable = 1'b0;
					end
				endcase
			end
			// Split sources ignore the routing field altogether
			`OCC_SRC_SPLIT_DAC_POS: begin
				next_route.driverEnable = 1'b1;
				next_route.posFromDac = 1'b1;
				next_route.negFromBypass = 1'b1;
			end
			`OCC_SRC_SPLIT_DAC_NEG: begin
				next_route.driverEnable = 1'b1;
				next_route.posFromBypass = 1'b1;
				next_route.negFromDac = 1'b1;
			end
			default: begin
				// Off and reserved source codes leave the driver disabled
				next_route = '0;
			end
		endcase
	end

	// Analog settings
	always_comb begin
		next_analog.commonModeHalfSupply = commonModeBit;
		next_analog.lowPowerActive = lowPowerBit & lowPowerAllowed;
		// Bandwidth lives in the positive-stage byte
		next_analog.wideBandwidth = bandwidthBit;
	end

	// Per-pin driver decode
	occ_stage_decode u_posDecode (
		.driveCode(posDriveCode),
		.levelCode(posLevelCode),
		.stage(next_posStage)
	);

	// The negative stage reuses the positive encodings
	occ_stage_decode u_negDecode (
		.driveCode(negDriveCode),
		.levelCode(negLevelCode),
		.stage(next_negStage)
	);

	// Reserved and forbidden codes are stored as written but reported here
	always_comb begin
		next_fault.sourceReserved = (sourceCode > `OCC_SRC_SPLIT_DAC_NEG);
		next_fault.routingReserved = (routingCode > `OCC_ROUTE_PSEUDO_POS_VCOM)
			& sourceUsesRouting;
		next_fault.posLevelIllegal = ~next_posStage.levelLegal;
		next_fault.negLevelIllegal = ~next_negStage.levelLegal;
	end

	// Registered outputs settle one cycle after a write
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			route <= '0;
		end else begin
			route <= next_route;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			analog <= '0;
		end else begin
			analog <= next_analog;
		end
	end

	// Each pin's stage registers apart, so a write to one never disturbs the other
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			posStage <= '0;
		end else begin
			posStage <= next_posStage;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			negStage <= '0;
		end else begin
			negStage <= next_negStage;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			fault <= '0;
		end else begin
			fault <= next_fault;
		end
	end

endmodule

`default_nettype wire

// [sim/occ_output_config_chk.sv]
// Assertions on the register port and decoded outputs of the bank
`timescale 1ns/1ps
`default_nettype none
module occ_output_config_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWriteData,
	input wire logic [7:0] regReadData,
	input wire logic regAck,
	input wire logic regHit,
	input wire occ_pkg::occ_route_t route,
	input wire occ_pkg::occ_analog_t analog,
	input wire occ_pkg::occ_stage_t posStage,
	input wire occ_pkg::occ_stage_t negStage,
	input wire occ_pkg::occ_fault_t fault
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Decoded outputs update one edge after the write edge and are sampled two edges on
	sequence wr_at(logic [7:0] a);
		regWrite && regAddr == a;
	endsequence
	sequence rd_at(logic [7:0] a);
		regRead && regAddr == a;
	endsequence
	ack_follow_a: assert property ((regWrite || regRead) |=> regAck)
		else $error("request not acknowledged");
	unmapped_read_a: assert property (regRead && !(regAddr inside {[8'h64:8'h66]})
		|=> regReadData == 8'h00 && !regHit) else $error("unmapped read not zero");
	pos_reserved_a: assert property (rd_at(8'h65) |=> regReadData[2:1] == 2'h0)
		else $error("reserved bits of 0x65 not zero");
	neg_reserved_a: assert property (rd_at(8'h66) |=> !regReadData[2])
		else $error("reserved bit of 0x66 not zero");
	source_off_a: assert property (wr_at(8'h64) ##0 regWriteData[7:5] == 3'h0
		|-> ##2 route == 8'h00) else $error("driver not off");
	split_src_a: assert property (wr_at(8'h64) ##0 regWriteData[7:5] == 3'h4
		|-> ##2 route.posFromDac && route.negFromBypass && !route.negFromDac)
		else $error("split source paths wrong");
	pos_level_a: assert property (wr_at(8'h65)
		|-> ##2 posStage.levelLegal == $past(regWriteData[5], 2)) else $error("level legality");
	pos_drive_a: assert property (wr_at(8'h65)
		|-> ##2 posStage.driveType == $past(regWriteData[7:6], 2)) else $error("pos drive");
	neg_drive_a: assert property (wr_at(8'h66)
		|-> ##2 negStage.driveType == $past(regWriteData[7:6], 2)) else $error("neg drive");
	bw_mode_a: assert property (wr_at(8'h65)
		|-> ##2 analog.wideBandwidth == $past(regWriteData[0], 2)) else $error("bandwidth");
	cm_select_a: assert property (wr_at(8'h64)
		|-> ##2 analog.commonModeHalfSupply == $past(regWriteData[1], 2)) else $error("vcom");
	low_power_a: assert property (analog.lowPowerActive
		|-> !route.posFromBypass && !route.negFromBypass) else $error("low power on bypass");
endmodule
`default_nettype wire

// [sim/test_occ_output_config.sv]
// Self-checking bench for the output channel configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_occ_output_config;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regWriteData = 8'h00;
	logic [7:0] regReadData;
	logic regAck;
	logic regHit;
	occ_pkg::occ_route_t route;
	occ_pkg::occ_analog_t analog;
	occ_pkg::occ_stage_t posStage;
	occ_pkg::occ_stage_t negStage;
	occ_pkg::occ_fault_t fault;
	int err_count = 0;
	int checked = 0;
	logic [2:0] s;
	logic [7:0] e;
	logic [7:0] a;
	always #10 clk_sys = ~clk_sys;
	occ_output_config u_occ_output_config (.clk_sys, .reset_n, .regAddr, .regWrite,
		.regRead, .regWriteData, .regReadData, .regAck, .regHit, .route, .analog,
		.posStage, .negStage, .fault);
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Strobe stays high so consecutive calls give back-to-back writes
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		regWrite = 1'b1;
		regAddr = ad;
		regWriteData = d;
		@(negedge clk_sys);
	endtask
	task automatic settle();
		regWrite = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		regWrite = 1'b0;
		regRead = 1'b1;
		regAddr = ad;
		@(negedge clk_sys);
		cmp({6'h00, regAck, regHit}, {7'h01, ad inside {[8'h64:8'h66]}});
		cmp(regReadData, exp);
		regRead = 1'b0;
		@(negedge clk_sys);
	endtask
	function automatic logic [7:0] exp_route(input logic [2:0] sc);
		case (sc)
			3'h1: return 8'hC8;
			3'h2: return 8'hA4;
			3'h3: return 8'hEC;
			3'h4: return 8'hC4;
			3'h5: return 8'hA8;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] exp_stage(input logic [1:0] d, input logic [2:0] l);
		logic [4:0] t;
		t = l[2] ? 5'h08 + 5'h06 * {3'h0, l[1:0]} : 5'h1A;
		return {d, t, l[2]};
	endfunction
	task automatic check_reset();
		cmp(route, 8'hC8);
		cmp(posStage, 8'h11);
		cmp(negStage, 8'h11);
		cmp({1'b0, analog, fault}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			rd(8'h64 + i[7:0], 8'h20);
		end
	endtask
	task automatic give_verdict();
		if (err_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		check_reset();
		for (int i = 0; i < 8; i++) begin
			s = i[2:0];
			wr(8'h64, {s, 5'h00});
			settle();
			cmp(route, exp_route(s));
			cmp({4'h0, fault}, {4'h0, s[2] & s[1], 3'h0});
			rd(8'h64, {s, 5'h00});
		end
		for (int i = 0; i < 8; i++) begin
			s = i[2:0];
			wr(8'h64, {3'h1, s, 2'h3});
			settle();
			cmp({5'h00, analog}, {6'h01, s != 3'h1, 1'b0});
			cmp({5'h00, route[4], route[1], route[0]}, {5'h00, s == 6, s == 4 || s == 5, s == 5});
			cmp({4'h0, fault}, {5'h00, s == 3'h7, 2'h0});
		end
		wr(8'h64, 8'h41);
		settle();
		cmp({5'h00, analog}, 8'h00);
		wr(8'h64, 8'h9C);
		settle();
		cmp(route, 8'hC4);
		cmp({4'h0, fault}, 8'h00);
		for (int i = 0; i < 16; i++) begin
			a = i[3] ? 8'h66 : 8'h65;
			e = {i[1:0], i[2:0], 3'h7} & (i[3] ? 8'hFB : 8'hF9);
			wr(a, e);
			settle();
			cmp(i[3] ? negStage : posStage, exp_stage(i[1:0], i[2:0]));
			cmp({4'h0, fault}, {6'h00, ~i[2] & ~i[3], ~i[2] & i[3]});
			cmp({5'h00, analog}, 8'h01);
			rd(a, e);
		end
		wr(8'h67, 8'h00);
		settle();
		rd(8'h67, 8'h00);
		rd(8'h63, 8'h00);
		rd(8'h66, 8'hFB);
		wr(8'h64, 8'hA0);
		wr(8'h64, 8'h60);
		settle();
		cmp(route, 8'hEC);
		rd(8'h64, 8'h60);
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		check_reset();
		give_verdict();
	end
endmodule
bind occ_output_config occ_output_config_chk u_occ_output_config_chk (.clk_sys, .reset_n,
	.regAddr, .regWrite, .regRead, .regWriteData, .regReadData, .regAck, .regHit,
	.route, .analog, .posStage, .negStage, .fault);
`default_nettype wire
